// ==== rtl/muxed_addr_pkg.sv ====
/*
  Constants for the multiplexed address command decoder: command codes,
  widths, burst settings, mode-register fields and the per-configuration
  latency tables.
  Assumes a single command clock shared with the controller.
*/
package muxed_addr_pkg;

  localparam int ADDR_BALLS = 19;
  localparam int ADDR_BITS  = 22;
  localparam int BANK_BITS  = 3;

  // command codes on the command pins
  typedef enum logic [1:0] {
    CMD_NOP     = 2'h0,
    CMD_READ    = 2'h1,
    CMD_WRITE   = 2'h2,
    CMD_REFRESH = 2'h3
  } cmd_t;

  typedef enum logic [1:0] {
    WIDTH_X9  = 2'h0,
    WIDTH_X18 = 2'h1,
    WIDTH_X36 = 2'h2
  } width_t;

  typedef enum logic [1:0] {
    BURST_2 = 2'h0,
    BURST_4 = 2'h1,
    BURST_8 = 2'h2
  } burst_t;

  // mode-register field that turns the two-part address on
  localparam int MUX_ENABLE_BIT = 5;

  localparam logic [2:0] CONFIG_RESET = 3'h1;
  localparam logic [3:0] READ_LAT_RESET = 4'h5;

  // read latency per configuration in multiplexed mode, index 1..5
  function automatic logic [3:0] read_latency_cycles(input logic [2:0] cfg);
    case (cfg)
      3'h1:    read_latency_cycles = 4'h5;
      3'h2:    read_latency_cycles = 4'h7;
      3'h3:    read_latency_cycles = 4'h9;
      3'h4:    read_latency_cycles = 4'h4;
      3'h5:    read_latency_cycles = 4'h6;
      default: read_latency_cycles = 4'h5;
    endcase
  endfunction : read_latency_cycles

  // write latency per configuration in multiplexed mode
  function automatic logic [3:0] write_latency_cycles(input logic [2:0] cfg);
    case (cfg)
      3'h1:    write_latency_cycles = 4'h6;
      3'h2:    write_latency_cycles = 4'h8;
      3'h3:    write_latency_cycles = 4'hA;
      3'h4:    write_latency_cycles = 4'h5;
      3'h5:    write_latency_cycles = 4'h7;
      default: write_latency_cycles = 4'h6;
    endcase
  endfunction : write_latency_cycles

endpackage : muxed_addr_pkg

// ==== rtl/muxed_address_command_decode.sv ====
/*
  Command and address capture of the memory in its two-part address mode.
  Assumes the controller drives command, bank and address balls from logic
  on the same clock, so no synchronisers; latency configuration, width and
  burst setting arrive as static inputs.
*/
// Contract
// - a mode register set with ball A5 high turns the two-part address format on.
// - the address comes in two parts on consecutive edges, bank and command with the first.
// - first-part balls A0,A3,A4,A5,A8,A9,A10,A13,A14,A17,A18 carry the same-numbered bits.
// - second-part balls A3,A4,A8,A9,A13,A14,A17,A18 carry bits A1,A2,A6,A7,A11,A12,A16,A15.
// - x36 burst eight ignores first-part ball A18, and x36 burst four or eight ignores second-part ball A10.
// - ball A10 of the second part is bit A19 for x36 burst two, x18 burst two/four and every x9 case.
// - second-part A0 is bit A20 for x18 burst two and x9 burst two/four; A5 is A21 only for x9 burst two.
// - don't-care ball positions never affect the decoded address.
// - multiplexed mode adds one cycle to read and write latency.
// - read data comes back after 5, 7, 9, 4 or 6 cycles per configuration.
// - auto refresh executes on the next edge using only its bank address.
// - after a refresh the next command may follow on the very next clock.
module muxed_address_command_decode
  import muxed_addr_pkg::*;
(
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // static configuration
  input  wire logic [2:0]            config_sel,
  input  wire width_t                data_width,
  input  wire burst_t                burst_length_setting,
  // command and address balls
  input  wire cmd_t                  cmd,
  input  wire logic                  mode_register_set_command,
  input  wire logic [BANK_BITS-1:0]  bank,
  input  wire logic [ADDR_BALLS-1:0] addr_ball,
  // decoded access
  output logic                       mux_mode,
  output logic                       access_valid,
  output cmd_t                       access_cmd,
  output logic [BANK_BITS-1:0]       access_bank,
  output logic [ADDR_BITS-1:0]       access_addr,
  output logic                       refresh_valid,
  output logic [BANK_BITS-1:0]       refresh_bank,
  output logic                       read_data_due,
  output logic                       write_data_due
);

  // ----------------------------------------
  // capture state
  // ----------------------------------------
  typedef enum logic [0:0] {
    ST_FIRST  = 1'b0,
    ST_SECOND = 1'b1
  } cap_state_t;

  cap_state_t             state, next_state;
  logic                   next_mux_mode;
  cmd_t                   held_cmd, next_held_cmd;
  logic [BANK_BITS-1:0]   held_bank, next_held_bank;
  logic [ADDR_BALLS-1:0]  held_first, next_held_first;
  logic                   next_access_valid, next_refresh_valid;
  cmd_t                   next_access_cmd;
  logic [BANK_BITS-1:0]   next_access_bank, next_refresh_bank;
  logic [ADDR_BITS-1:0]   next_access_addr;
  logic [ADDR_BITS-1:0]   mapped;
  logic [15:0]            rd_pipe, wr_pipe, next_rd_pipe, next_wr_pipe;
  logic [3:0]             rl, wl;

  // two-part address mapping by width and burst
  always_comb begin
    mapped = '0;
    // first part: straight bits
    mapped[0]  = held_first[0];
    mapped[3]  = held_first[3];
    mapped[4]  = held_first[4];
    mapped[5]  = held_first[5];
    mapped[8]  = held_first[8];
    mapped[9]  = held_first[9];
    mapped[10] = held_first[10];
    mapped[13] = held_first[13];
    mapped[14] = held_first[14];
    mapped[17] = held_first[17];
    if (!(data_width == WIDTH_X36 && burst_length_setting == BURST_8)) begin
      mapped[18] = held_first[18];
    end
    // second part: fixed remap
    mapped[1]  = addr_ball[3];
    mapped[2]  = addr_ball[4];
    mapped[6]  = addr_ball[8];
    mapped[7]  = addr_ball[9];
    mapped[11] = addr_ball[13];
    mapped[12] = addr_ball[14];
    mapped[16] = addr_ball[17];
    mapped[15] = addr_ball[18];
    if ((data_width == WIDTH_X36 && burst_length_setting == BURST_2)
        || (data_width == WIDTH_X18 && burst_length_setting != BURST_8)
        || data_width == WIDTH_X9) begin
      mapped[19] = addr_ball[10];
    end
    if ((data_width == WIDTH_X18 && burst_length_setting == BURST_2)
        || (data_width == WIDTH_X9 && burst_length_setting != BURST_8)) begin
      mapped[20] = addr_ball[0];
    end
    if (data_width == WIDTH_X9 && burst_length_setting == BURST_2) begin
      mapped[21] = addr_ball[5];
    end
  end

  assign rl = read_latency_cycles(config_sel);
  assign wl = write_latency_cycles(config_sel);

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    next_state         = state;
    next_mux_mode      = mux_mode;
    next_held_cmd      = held_cmd;
    next_held_bank     = held_bank;
    next_held_first    = held_first;
    next_access_valid  = 1'b0;
    next_access_cmd    = access_cmd;
    next_access_bank   = access_bank;
    next_access_addr   = access_addr;
    next_refresh_valid = 1'b0;
    next_refresh_bank  = refresh_bank;
    next_rd_pipe       = {1'b0, rd_pipe[15:1]};
    next_wr_pipe       = {1'b0, wr_pipe[15:1]};
    case (state)
      ST_FIRST: begin
        if (mode_register_set_command) begin
          next_mux_mode = addr_ball[MUX_ENABLE_BIT];
          // a mode register set in muxed mode still takes two parts
          if (mux_mode) begin
            next_state = ST_SECOND;
          end
        end else if (cmd == CMD_REFRESH) begin
          // no second part, next edge is free for a new command
          next_refresh_valid = 1'b1;
          next_refresh_bank  = bank;
        end else if (cmd == CMD_READ || cmd == CMD_WRITE) begin
          if (mux_mode) begin
            next_held_cmd   = cmd;
            next_held_bank  = bank;
            next_held_first = addr_ball;
            next_state      = ST_SECOND;
          end else begin
            next_access_valid = 1'b1;
            next_access_cmd   = cmd;
            next_access_bank  = bank;
            next_access_addr  = {3'h0, addr_ball};
          end
        end
      end
      ST_SECOND: begin
        // command pins ignored while second part is on the balls
        next_state = ST_FIRST;
        if (held_cmd != CMD_NOP) begin
          next_access_valid = 1'b1;
          next_access_cmd   = held_cmd;
          next_access_bank  = held_bank;
          next_access_addr  = mapped;
          // latencies count from the first-part edge, one edge already gone
          if (held_cmd == CMD_READ) begin
            next_rd_pipe[rl - 4'h2] = 1'b1;
          end else begin
            next_wr_pipe[wl - 4'h2] = 1'b1;
          end
        end
        next_held_cmd = CMD_NOP;
      end
      default: next_state = ST_FIRST;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state          <= ST_FIRST;
      mux_mode       <= 1'b0;
      held_cmd       <= CMD_NOP;
      held_bank      <= '0;
      held_first     <= '0;
      access_valid   <= 1'b0;
      access_cmd     <= CMD_NOP;
      access_bank    <= '0;
      access_addr    <= '0;
      refresh_valid  <= 1'b0;
      refresh_bank   <= '0;
      rd_pipe        <= '0;
      wr_pipe        <= '0;
      read_data_due  <= 1'b0;
      write_data_due <= 1'b0;
    end else begin
      state          <= next_state;
      mux_mode       <= next_mux_mode;
      held_cmd       <= next_held_cmd;
      held_bank      <= next_held_bank;
      held_first     <= next_held_first;
      access_valid   <= next_access_valid;
      access_cmd     <= next_access_cmd;
      access_bank    <= next_access_bank;
      access_addr    <= next_access_addr;
      refresh_valid  <= next_refresh_valid;
      refresh_bank   <= next_refresh_bank;
      rd_pipe        <= next_rd_pipe;
      wr_pipe        <= next_wr_pipe;
      read_data_due  <= next_rd_pipe[0];
      write_data_due <= next_wr_pipe[0];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_mode_enable: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_FIRST && mode_register_set_command) |=> mux_mode == $past(addr_ball[MUX_ENABLE_BIT]))
    else $error("mux mode not taken from A5");
  chk_two_part: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_FIRST && !mode_register_set_command && mux_mode && cmd == CMD_READ)
      |=> ##1 access_valid && access_cmd == CMD_READ)
    else $error("read not issued after second part");
  chk_second_map: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_SECOND && held_cmd != CMD_NOP) |=> access_addr[1] == $past(addr_ball[3])
      && access_addr[15] == $past(addr_ball[18]))
    else $error("second part remap wrong");
  chk_x36_dontcare: assert property (@(posedge sys_clk) disable iff (rst)
    (access_valid && mux_mode && data_width == WIDTH_X36 && burst_length_setting == BURST_8)
      |-> access_addr[19:18] == 2'h0)
    else $error("x36 burst eight don't care leaked");
  chk_high_bits: assert property (@(posedge sys_clk) disable iff (rst)
    (access_valid && mux_mode && data_width != WIDTH_X9) |-> access_addr[21] == 1'b0)
    else $error("bit 21 set outside x9");
  chk_refresh_next: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_FIRST && !mode_register_set_command && cmd == CMD_REFRESH)
      |=> refresh_valid && refresh_bank == $past(bank) && state == ST_FIRST)
    else $error("refresh not executed on next edge");
  chk_read_lat4: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_FIRST && mux_mode && !mode_register_set_command && cmd == CMD_READ && config_sel == 3'h4)
      |-> ##4 read_data_due)
    else $error("read latency four missed");
  chk_read_lat5: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_FIRST && mux_mode && !mode_register_set_command && cmd == CMD_READ && config_sel == 3'h1)
      |-> ##5 read_data_due)
    else $error("read latency five missed");
  cov_refresh: cover property (@(posedge sys_clk) refresh_valid ##2 access_valid);
  cov_read: cover property (@(posedge sys_clk) read_data_due);
  cov_write: cover property (@(posedge sys_clk) write_data_due);

endmodule : muxed_address_command_decode

// ==== tb/mem_ctrl_model.sv ====
/*
  Controller-side model: drives command, bank and address balls in the
  two-part format, one ball set per falling edge.
  Assumes the bench calls its tasks in order and holds width and burst static.
*/
module mem_ctrl_model
  import muxed_addr_pkg::*;
(
  // clock and configuration
  input  wire logic                  sys_clk,
  input  wire width_t                data_width,
  input  wire burst_t                burst_length_setting,
  // command and address balls
  output cmd_t                       cmd,
  output logic                       mode_register_set_command,
  output logic [BANK_BITS-1:0]       bank,
  output logic [ADDR_BALLS-1:0]      addr_ball
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int BALL [11] = '{0, 3, 4, 5, 8, 9, 10, 13, 14, 17, 18};
  localparam int HIGH [11] = '{20, 1, 2, 21, 6, 7, 19, 11, 12, 16, 15};

  initial begin
    cmd = CMD_NOP;
    mode_register_set_command = 1'b0;
    bank = 3'h0;
    addr_ball = 19'h0;
  end

  // address bits that survive the mapping; the rest are don't care
  function automatic logic [21:0] addr_mask(input width_t w, input burst_t len);
    addr_mask = 22'h3FFFFF;
    addr_mask[18] = !(w == WIDTH_X36 && len == BURST_8);
    addr_mask[19] = w == WIDTH_X9 || (w == WIDTH_X18 && len != BURST_8) || (w == WIDTH_X36 && len == BURST_2);
    addr_mask[20] = (len == BURST_2 && w != WIDTH_X36) || (w == WIDTH_X9 && len == BURST_4);
    addr_mask[21] = w == WIDTH_X9 && len == BURST_2;
  endfunction : addr_mask

  // don't-care balls get the inverse of their last level, never a kind value
  task automatic send_part(input cmd_t c, input logic set_mode, input logic [2:0] bk, input logic [21:0] a,
                           input logic second);
    logic [18:0] b;
    logic [21:0] m;
    m = addr_mask(data_width, burst_length_setting);
    b = ~addr_ball;
    for (int i = 0; i < 11; i++) begin
      if (m[second ? HIGH[i] : BALL[i]]) b[BALL[i]] = a[second ? HIGH[i] : BALL[i]];
    end
    @(negedge sys_clk);
    cmd = second ? CMD_REFRESH : c;
    mode_register_set_command = second ? 1'b0 : set_mode;
    bank = second ? ~bank : bk;
    addr_ball = b;
  endtask : send_part

  task automatic idle();
    @(negedge sys_clk);
    cmd = CMD_NOP;
    mode_register_set_command = 1'b0;
    bank = ~bank;
    addr_ball = ~addr_ball;
  endtask : idle
endmodule : mem_ctrl_model

// ==== tb/muxed_address_command_decode_tb_top.sv ====
/*
  Self-checking bench: every width and burst setting, mode entry, muxed
  accesses with latency pulses, refresh followed at once by a muxed access.
  Assumes the controller model drives the balls at falling edges.
*/
module muxed_address_command_decode_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import muxed_addr_pkg::*;

  logic                  sys_clk = 1'b0;
  logic                  rst = 1'b1;
  logic [2:0]            config_sel = 3'h1;
  width_t                data_width = WIDTH_X36;
  burst_t                burst_length_setting = BURST_2;
  cmd_t                  cmd;
  cmd_t                  access_cmd;
  logic                  mode_reg_set;
  logic [2:0]            bank;
  logic [2:0]            access_bank;
  logic [2:0]            refresh_bank;
  logic [18:0]           addr_ball;
  logic [21:0]           access_addr;
  logic                  mux_mode;
  logic                  access_valid;
  logic                  refresh_valid;
  logic                  read_data_due;
  logic                  write_data_due;
  int                    errors = 0;
  int                    checked = 0;
  logic [31:0]           lfsr = 32'h43A50F2A;
  localparam int         RL [5] = '{5, 7, 9, 4, 6};

  always #12.5 sys_clk = ~sys_clk;

  muxed_address_command_decode dut_u (.sys_clk(sys_clk), .rst(rst), .config_sel(config_sel),
    .data_width(data_width), .burst_length_setting(burst_length_setting), .cmd(cmd),
    .mode_register_set_command(mode_reg_set), .bank(bank), .addr_ball(addr_ball), .mux_mode(mux_mode),
    .access_valid(access_valid), .access_cmd(access_cmd), .access_bank(access_bank),
    .access_addr(access_addr), .refresh_valid(refresh_valid), .refresh_bank(refresh_bank),
    .read_data_due(read_data_due), .write_data_due(write_data_due));

  mem_ctrl_model ctrl_u (.sys_clk(sys_clk), .data_width(data_width),
    .burst_length_setting(burst_length_setting), .cmd(cmd), .mode_register_set_command(mode_reg_set),
    .bank(bank), .addr_ball(addr_ball));

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand

  task automatic check(input logic ok, input string what);
    checked++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : check

  task automatic summarize();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------
  // one muxed access, optionally right behind a refresh
  // ---------------------------------------------------------------
  task automatic mux_access(input cmd_t c, input logic [2:0] bk, input logic [21:0] a, input logic pre_ref);
    logic [21:0] e;
    int          rl;
    e = a & ctrl_u.addr_mask(data_width, burst_length_setting);
    rl = RL[config_sel - 3'h1];
    if (pre_ref) ctrl_u.send_part(CMD_REFRESH, 1'b0, bk ^ 3'h1, ~a, 1'b0);
    ctrl_u.send_part(c, 1'b0, bk, a, 1'b0);
    check(refresh_valid === pre_ref && (!pre_ref || refresh_bank === (bk ^ 3'h1)), "refresh");
    ctrl_u.send_part(c, 1'b0, bk, a, 1'b1);
    ctrl_u.idle();
    // the access pulse stands only between the second-part edge and the next one
    check(access_valid === 1'b1 && access_cmd === c && access_bank === bk, "access cmd");
    check(access_addr === e, "access address");
    // wait past the longest write latency, which also keeps the row cycle
    for (int n = 3; n <= 11; n++) begin
      @(negedge sys_clk);
      check(read_data_due === (c == CMD_READ && n == rl) && write_data_due === (c == CMD_WRITE && n == rl + 1)
            && (n != 3 || access_valid === 1'b0), "latency pulse");
    end
  endtask : mux_access

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(negedge sys_clk);
    for (int k = 0; k < 9; k++) begin
      rst = 1'b1;
      data_width = width_t'(k / 3);
      burst_length_setting = burst_t'(k % 3);
      config_sel = 3'(k % 5 + 1);
      if (k % 3 == 2 && (config_sel == 3'h1 || config_sel == 3'h4)) config_sel += 3'h1;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      ctrl_u.send_part(CMD_READ, 1'b0, 3'h2, lfsr[21:0], 1'b0);
      ctrl_u.idle();
      check(access_valid === 1'b1 && access_addr === {3'h0, ~addr_ball} && mux_mode === 1'b0, "plain");
      repeat (12) @(negedge sys_clk);
      ctrl_u.send_part(CMD_NOP, 1'b1, 3'h0, 22'h20, 1'b0);
      ctrl_u.idle();
      check(mux_mode === 1'b1, "mode entry");
      ctrl_u.send_part(CMD_NOP, 1'b1, 3'h0, 22'h20, 1'b0);
      ctrl_u.send_part(CMD_NOP, 1'b0, 3'h0, 22'h0, 1'b1);
      ctrl_u.idle();
      check(mux_mode === 1'b1 && refresh_valid === 1'b0 && access_valid === 1'b0, "muxed mode set");
      for (int j = 0; j < 6; j++) begin
        lfsr = next_rand(lfsr);
        mux_access(j == 0 ? CMD_WRITE : ((j == 1 || lfsr[31]) ? CMD_READ : CMD_WRITE), lfsr[24:22],
                   j == 1 ? 22'h3FFFFF : (j == 2 ? 22'h0 : lfsr[21:0]), j % 3 == 0);
      end
      // leaving muxed mode also takes two parts
      ctrl_u.send_part(CMD_NOP, 1'b1, 3'h0, 22'h0, 1'b0);
      ctrl_u.send_part(CMD_NOP, 1'b0, 3'h0, 22'h0, 1'b1);
      ctrl_u.idle();
      check(mux_mode === 1'b0 && access_valid === 1'b0 && refresh_valid === 1'b0, "mode exit");
    end
    summarize();
  end

  initial begin
    #125000;
    errors++;
    summarize();
  end
endmodule : muxed_address_command_decode_tb_top
